// [sbs_jtag_host.sv]
// Board-side test controller model for the serial test port.
// Assumes one caller at a time; tasks start while the test clock is low.
module sbs_jtag_host (
   // Serial test port
   output logic o_tck,
   output logic o_tms,
   output logic o_tms_driven,
   output logic o_tdi,
   output logic o_tdi_driven,
   input wire logic i_tdo,
   input wire logic i_tdo_oe_b
);
   timeunit 1ns;
   timeprecision 100ps;
   logic drv = 1'b1;
   logic shifting = 1'b0;
   int oe_err = 0;
   // Driven flags follow the release state
   assign o_tms_driven = drv;
   assign o_tdi_driven = drv;
   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
   end
   // drive after fall, sample at rise
   task automatic step(input logic t, input logic d, output logic s);
      if (drv) begin
         o_tms <= t;
         o_tdi <= d;
      end else begin
         o_tms <= ~o_tms; // Released pins wander
         o_tdi <= ~o_tdi;
      end
      #24 o_tck = 1'b1;
      s = i_tdo;
      if (shifting && i_tdo_oe_b !== 1'b0) oe_err++;
      #24 o_tck = 1'b0;
   endtask
   // Five ones and more reach reset, then idle
   task automatic tlr();
      logic s;
      repeat (6) step(1'b1, 1'b1, s);
      step(1'b0, 1'b0, s);
   endtask
   // Idle to shift, n bits lsb first, update, idle
   task automatic scan(input logic ir, input int n, input logic [127:0] din,
         output logic [127:0] dout);
      logic s;
      dout = '0;
      step(1'b1, 1'b0, s);
      if (ir) step(1'b1, 1'b0, s);
      step(1'b0, 1'b0, s);
      step(1'b0, 1'b0, s);
      shifting = 1'b1;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], s);
         dout[i] = s;
      end
      shifting = 1'b0;
      step(1'b1, 1'b0, s);
      step(1'b0, 1'b0, s);
   endtask
   task automatic load_ir(input logic [2:0] c, output logic [127:0] cap);
      cap = '0;
      if (c inside {3'h3, 3'h5, 3'h6}) return;
      scan(1'b1, 3, {125'h0, c}, cap);
   endtask
   // pins left undriven for five clocks
   task automatic float_reset();
      logic s;
      drv = 1'b0;
      repeat (5) step(1'b0, 1'b0, s);
      drv = 1'b1;
      step(1'b0, 1'b0, s);
   endtask
endmodule

// [sbs_pkg.sv]
// Shared constants and types for the SRAM boundary scan test port.
// Assumes one APB slave on the reference clock and a test clock domain.
package sbs_pkg;
   // Register widths
   localparam int IR_W = 3;
   localparam int ID_W = 32;
   localparam int BSR_W = 107;
   // Instruction codes
   localparam logic [2:0] INS_EXTEST = 3'h0;
   localparam logic [2:0] INS_IDCODE = 3'h1;
   localparam logic [2:0] INS_SAMPLEZ = 3'h2;
   localparam logic [2:0] INS_PRELOAD = 3'h4;
   localparam logic [2:0] INS_BYPASS = 3'h7;
   // Fixed instruction capture pattern
   localparam logic [2:0] IR_CAPTURE = 3'h1;
   // Identification field positions
   localparam int ID_REV_LSB = 29;
   localparam int ID_DEV_LSB = 12;
   localparam int ID_VEN_LSB = 1;
   // APB register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   // Control register fields and reset
   localparam int CTRL_DRIVE_EN = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   // Status register fields
   localparam int ST_TLR = 0;
   localparam int ST_DRIVE = 1;
   localparam int ST_HIZ = 2;
   localparam int ST_SHIFT = 3;
   // Controller states
   typedef enum logic [3:0] {
      ST_TEST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
      ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR,
      ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
   } sbs_tap_state_t;
endpackage

// [sbs_tap.sv]
// Test access port, instruction, bypass, id and boundary chain of the SRAM.
// Assumes a power-on reset on I_RST_B, APB on I_REF_CLK, test clock on I_TCK.

// Notes on behaviour
// RULE1 - Sixteen-state controller; power-on reset forces test-logic-reset, no test reset pin.
// RULE2 - Instruction 3 bits, bypass 1 bit, identification 32 bits, boundary 107 bits.
// RULE3 - Undriven mode select or data input behaves as logic one.
// RULE4 - Outside party grounds the test clock when the port is unused.
// RULE5 - External test and sample codes put the boundary chain in path, capturing pads.
// RULE6 - Sample-with-high-impedance code floats data pins and samples all inputs.
// RULE7 - Sample/preload routes boundary chain to output; outputs stay enabled.
// RULE8 - Identification code routes id register out; data input enters first bit; code shifts it into bit 31.
// RULE9 - Bypass code clears bypass bit and routes it between data in and out.
// RULE10 - Bypass bit keeps the last shifted-in bit after leaving shift.
// RULE11 - Controller never loads codes 011, 101 or 110.
// RULE12 - Id register holds revision 31:29, device 28:12, vendor 11:1.
// RULE13 - Id register bit zero reads as constant one.
// RULE14 - Inputs sampled on rising test clock; output changes falling, driven only shifting.
// RULE15 - Test-logic-reset loads the identification instruction.
module sbs_tap #(
   parameter logic [2:0] REV_ID = 3'h5,       // Arbitrary value
   parameter logic [16:0] DEVICE_ID = 17'h0aa, // Arbitrary value
   parameter logic [10:0] VENDOR_ID = 11'h155  // Arbitrary value
) (
   // Reference clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_RST_B,
   // APB slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   // Test port link
   input wire logic I_TCK,
   input wire logic I_TMS,
   input wire logic I_TMS_DRIVEN,
   input wire logic I_TDI,
   input wire logic I_TDI_DRIVEN,
   output logic O_TDO,
   output logic O_TDO_OE_B,
   // Package pads
   input wire logic [sbs_pkg::BSR_W-1:0] I_PAD_IN,
   output logic [sbs_pkg::BSR_W-1:0] O_PAD_OUT,
   output logic O_PAD_DRIVE,
   output logic O_DQ_HIZ
);
   localparam logic [31:0] ID_VALUE = {REV_ID, DEVICE_ID, VENDOR_ID, 1'b1};

   logic tck_rst_meta, tck_rst_n;
   logic allow_meta, allow_sync;
   logic [sbs_pkg::BSR_W-1:0] pad_meta, pad_sync;
   sbs_pkg::sbs_tap_state_t state_reg;
   logic tms, tdi;
   logic [2:0] ir_sr, ir_reg;
   logic bypass_reg;
   logic [31:0] id_sr;
   logic [sbs_pkg::BSR_W-1:0] bsr_sr, bsr_upd;
   logic drive_reg, hiz_reg, tlr_reg, shift_reg;
   logic tdo_reg, tdo_oe_b_reg, dr_out;
   logic [31:0] ctrl_reg, rdata_reg;
   logic [3:0] st_meta, st_sync;
   logic bsr_sel, id_sel;

   // Next controller state
   function automatic sbs_pkg::sbs_tap_state_t tap_next(sbs_pkg::sbs_tap_state_t s, logic m);
      case (s)
         sbs_pkg::ST_TEST_RESET: tap_next = m ? sbs_pkg::ST_TEST_RESET : sbs_pkg::ST_IDLE;
         sbs_pkg::ST_IDLE: tap_next = m ? sbs_pkg::ST_SEL_DR : sbs_pkg::ST_IDLE;
         sbs_pkg::ST_SEL_DR: tap_next = m ? sbs_pkg::ST_SEL_IR : sbs_pkg::ST_CAP_DR;
         sbs_pkg::ST_CAP_DR: tap_next = m ? sbs_pkg::ST_EXIT1_DR : sbs_pkg::ST_SHIFT_DR;
         sbs_pkg::ST_SHIFT_DR: tap_next = m ? sbs_pkg::ST_EXIT1_DR : sbs_pkg::ST_SHIFT_DR;
         sbs_pkg::ST_EXIT1_DR: tap_next = m ? sbs_pkg::ST_UPD_DR : sbs_pkg::ST_PAUSE_DR;
         sbs_pkg::ST_PAUSE_DR: tap_next = m ? sbs_pkg::ST_EXIT2_DR : sbs_pkg::ST_PAUSE_DR;
         sbs_pkg::ST_EXIT2_DR: tap_next = m ? sbs_pkg::ST_UPD_DR : sbs_pkg::ST_SHIFT_DR;
         sbs_pkg::ST_UPD_DR: tap_next = m ? sbs_pkg::ST_SEL_DR : sbs_pkg::ST_IDLE;
         sbs_pkg::ST_SEL_IR: tap_next = m ? sbs_pkg::ST_TEST_RESET : sbs_pkg::ST_CAP_IR;
         sbs_pkg::ST_CAP_IR: tap_next = m ? sbs_pkg::ST_EXIT1_IR : sbs_pkg::ST_SHIFT_IR;
         sbs_pkg::ST_SHIFT_IR: tap_next = m ? sbs_pkg::ST_EXIT1_IR : sbs_pkg::ST_SHIFT_IR;
         sbs_pkg::ST_EXIT1_IR: tap_next = m ? sbs_pkg::ST_UPD_IR : sbs_pkg::ST_PAUSE_IR;
         sbs_pkg::ST_PAUSE_IR: tap_next = m ? sbs_pkg::ST_EXIT2_IR : sbs_pkg::ST_PAUSE_IR;
         sbs_pkg::ST_EXIT2_IR: tap_next = m ? sbs_pkg::ST_UPD_IR : sbs_pkg::ST_SHIFT_IR;
         sbs_pkg::ST_UPD_IR: tap_next = m ? sbs_pkg::ST_SEL_DR : sbs_pkg::ST_IDLE;
         default: tap_next = sbs_pkg::ST_TEST_RESET;
      endcase
   endfunction

   // Power-on reset into test clock domain, released on the clock
   always_ff @(posedge I_TCK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         tck_rst_meta <= 1'b0;
         tck_rst_n <= 1'b0;
      end else begin
         tck_rst_meta <= 1'b1;
         tck_rst_n <= tck_rst_meta;
      end
   end

   // Software drive enable and pad levels into test clock domain
   always_ff @(posedge I_TCK or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         allow_meta <= 1'b0;
         allow_sync <= 1'b0;
         pad_meta <= '0;
         pad_sync <= '0;
      end else begin
         allow_meta <= ctrl_reg[sbs_pkg::CTRL_DRIVE_EN];
         allow_sync <= allow_meta;
         pad_meta <= I_PAD_IN;
         pad_sync <= pad_meta;
      end
   end

   // RULE3 undriven reads one
   assign tms = I_TMS_DRIVEN ? I_TMS : 1'b1;
   assign tdi = I_TDI_DRIVEN ? I_TDI : 1'b1;

   // RULE1 controller state, reset at power-up
   always_ff @(posedge I_TCK or negedge tck_rst_n) begin
      if (!tck_rst_n)
         state_reg <= sbs_pkg::ST_TEST_RESET;
      else
         state_reg <= tap_next(state_reg, tms);
   end

   // RULE2 instruction shift stage
   always_ff @(posedge I_TCK or negedge tck_rst_n) begin
      if (!tck_rst_n)
         ir_sr <= sbs_pkg::IR_CAPTURE;
      else if (state_reg == sbs_pkg::ST_CAP_IR)
         ir_sr <= sbs_pkg::IR_CAPTURE;
      else if (state_reg == sbs_pkg::ST_SHIFT_IR)
         ir_sr <= {tdi, ir_sr[2:1]};
   end

   // RULE15 instruction and pin modes, idcode at reset
   always_ff @(posedge I_TCK or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         ir_reg <= sbs_pkg::INS_IDCODE;
         drive_reg <= 1'b0;
         hiz_reg <= 1'b0;
      end else if (state_reg == sbs_pkg::ST_TEST_RESET) begin
         ir_reg <= sbs_pkg::INS_IDCODE;
         drive_reg <= 1'b0;
         hiz_reg <= 1'b0;
      end else if (state_reg == sbs_pkg::ST_UPD_IR) begin
         ir_reg <= ir_sr;
         // RULE6 high impedance; RULE7 preload keeps outputs
         drive_reg <= (ir_sr == sbs_pkg::INS_EXTEST) && allow_sync;
         hiz_reg <= (ir_sr == sbs_pkg::INS_SAMPLEZ);
      end
   end

   // Chain selection; reserved codes fall back to bypass
   assign bsr_sel = (ir_reg == sbs_pkg::INS_EXTEST) || (ir_reg == sbs_pkg::INS_SAMPLEZ) ||
                    (ir_reg == sbs_pkg::INS_PRELOAD);
   assign id_sel = (ir_reg == sbs_pkg::INS_IDCODE);

   // RULE9 bypass cleared on load; RULE10 holds last bit
   always_ff @(posedge I_TCK or negedge tck_rst_n) begin
      if (!tck_rst_n)
         bypass_reg <= 1'b0;
      else if (state_reg == sbs_pkg::ST_UPD_IR && ir_sr == sbs_pkg::INS_BYPASS)
         bypass_reg <= 1'b0;
      else if (state_reg == sbs_pkg::ST_CAP_DR && !bsr_sel && !id_sel)
         bypass_reg <= 1'b0;
      else if (state_reg == sbs_pkg::ST_SHIFT_DR && !bsr_sel && !id_sel)
         bypass_reg <= tdi;
   end

   // RULE12 RULE13 id capture; RULE8 serial shift
   always_ff @(posedge I_TCK or negedge tck_rst_n) begin
      if (!tck_rst_n)
         id_sr <= ID_VALUE;
      else if (state_reg == sbs_pkg::ST_CAP_DR && id_sel)
         id_sr <= ID_VALUE;
      else if (state_reg == sbs_pkg::ST_SHIFT_DR && id_sel)
         id_sr <= {tdi, id_sr[31:1]};
   end

   // RULE5 boundary chain captures pads and shifts
   always_ff @(posedge I_TCK or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         bsr_sr <= '0;
         bsr_upd <= '0;
      end else begin
         if (state_reg == sbs_pkg::ST_CAP_DR && bsr_sel)
            bsr_sr <= pad_sync;
         else if (state_reg == sbs_pkg::ST_SHIFT_DR && bsr_sel)
            bsr_sr <= {tdi, bsr_sr[sbs_pkg::BSR_W-1:1]};
         if (state_reg == sbs_pkg::ST_UPD_DR && bsr_sel)
            bsr_upd <= bsr_sr;
      end
   end

   // Status levels for software
   always_ff @(posedge I_TCK or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         tlr_reg <= 1'b1;
         shift_reg <= 1'b0;
      end else begin
         tlr_reg <= (state_reg == sbs_pkg::ST_TEST_RESET);
         shift_reg <= (state_reg == sbs_pkg::ST_SHIFT_DR) || (state_reg == sbs_pkg::ST_SHIFT_IR);
      end
   end

   assign dr_out = bsr_sel ? bsr_sr[0] : (id_sel ? id_sr[0] : bypass_reg);

   // RULE14 output changes on falling edge, enabled only shifting
   always_ff @(negedge I_TCK or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         tdo_reg <= 1'b0;
         tdo_oe_b_reg <= 1'b1;
      end else begin
         tdo_oe_b_reg <= !((state_reg == sbs_pkg::ST_SHIFT_DR) ||
                           (state_reg == sbs_pkg::ST_SHIFT_IR));
         if (state_reg == sbs_pkg::ST_SHIFT_IR)
            tdo_reg <= ir_sr[0];
         else if (state_reg == sbs_pkg::ST_SHIFT_DR)
            tdo_reg <= dr_out;
      end
   end

   assign O_TDO = tdo_reg;
   assign O_TDO_OE_B = tdo_oe_b_reg;
   assign O_PAD_OUT = bsr_upd;
   assign O_PAD_DRIVE = drive_reg;
   assign O_DQ_HIZ = hiz_reg;

   // Status levels into reference domain
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         st_meta <= 4'h0;
         st_sync <= 4'h0;
      end else begin
         st_meta <= {shift_reg, hiz_reg, drive_reg, tlr_reg};
         st_sync <= st_meta;
      end
   end

   // APB control register, written in access phase
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B)
         ctrl_reg <= sbs_pkg::CTRL_RESET;
      else if (I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == sbs_pkg::OFF_CTRL)
         ctrl_reg <= {31'h0, I_PWDATA[sbs_pkg::CTRL_DRIVE_EN]};
   end

   // APB read data latched in setup phase
   always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
      if (!I_RST_B)
         rdata_reg <= 32'h0;
      else if (I_PSEL && !I_PENABLE) begin
         case (I_PADDR)
            sbs_pkg::OFF_CTRL: rdata_reg <= ctrl_reg;
            sbs_pkg::OFF_STATUS: rdata_reg <= {28'h0, st_sync};
            default: rdata_reg <= 32'h0;
         endcase
      end
   end

   assign O_PRDATA = rdata_reg;
   assign O_PREADY = 1'b1;
   assign O_PSLVERR = I_PSEL && I_PENABLE &&
                      (I_PADDR != sbs_pkg::OFF_CTRL) && (I_PADDR != sbs_pkg::OFF_STATUS);

   // Checks
   property p_tms_reset;
      @(posedge I_TCK) disable iff (!tck_rst_n)
      (tms == 1'b1) [*5] |=> (state_reg == sbs_pkg::ST_TEST_RESET);
   endproperty
   a_tms_reset: assert property (p_tms_reset) else $error("five tms highs not reset"); // RULE1

   property p_reset_idcode;
      @(posedge I_TCK) disable iff (!tck_rst_n)
      (state_reg == sbs_pkg::ST_TEST_RESET) |=> (ir_reg == sbs_pkg::INS_IDCODE);
   endproperty
   a_reset_idcode: assert property (p_reset_idcode) else $error("reset not idcode"); // RULE15

   property p_bsr_capture;
      @(posedge I_TCK) disable iff (!tck_rst_n)
      (state_reg == sbs_pkg::ST_CAP_DR && bsr_sel) |=> (bsr_sr == $past(pad_sync));
   endproperty
   a_bsr_capture: assert property (p_bsr_capture) else $error("pads not captured"); // RULE5

   property p_samplez_hiz;
      @(posedge I_TCK) disable iff (!tck_rst_n)
      (state_reg == sbs_pkg::ST_UPD_IR && ir_sr == sbs_pkg::INS_SAMPLEZ) |=> hiz_reg && bsr_sel;
   endproperty
   a_samplez_hiz: assert property (p_samplez_hiz) else $error("sample-z not floating"); // RULE6

   property p_preload_keep;
      @(posedge I_TCK) disable iff (!tck_rst_n)
      (ir_reg == sbs_pkg::INS_PRELOAD) |-> !hiz_reg && !drive_reg;
   endproperty
   a_preload_keep: assert property (p_preload_keep) else $error("preload altered pins"); // RULE7

   property p_id_shift;
      @(posedge I_TCK) disable iff (!tck_rst_n)
      (state_reg == sbs_pkg::ST_SHIFT_DR && id_sel) |=> (id_sr[31] == $past(tdi));
   endproperty
   a_id_shift: assert property (p_id_shift) else $error("id not shifting tdi"); // RULE8

   property p_id_capture;
      @(posedge I_TCK) disable iff (!tck_rst_n)
      (state_reg == sbs_pkg::ST_CAP_DR && id_sel) |=> (id_sr == ID_VALUE) && id_sr[0];
   endproperty
   a_id_capture: assert property (p_id_capture) else $error("id value wrong"); // RULE12

   property p_bypass_clear;
      @(posedge I_TCK) disable iff (!tck_rst_n)
      (state_reg == sbs_pkg::ST_CAP_DR && ir_reg == sbs_pkg::INS_BYPASS) |=> !bypass_reg;
   endproperty
   a_bypass_clear: assert property (p_bypass_clear) else $error("bypass not cleared"); // RULE9

   property p_bypass_hold;
      @(posedge I_TCK) disable iff (!tck_rst_n)
      (state_reg == sbs_pkg::ST_EXIT1_DR && $past(state_reg) == sbs_pkg::ST_SHIFT_DR &&
       ir_reg == sbs_pkg::INS_BYPASS) |-> (bypass_reg == $past(tdi));
   endproperty
   a_bypass_hold: assert property (p_bypass_hold) else $error("bypass lost bit"); // RULE10

   property p_tdo_quiet;
      @(negedge I_TCK) disable iff (!tck_rst_n)
      !(state_reg == sbs_pkg::ST_SHIFT_DR || state_reg == sbs_pkg::ST_SHIFT_IR) |=> O_TDO_OE_B;
   endproperty
   a_tdo_quiet: assert property (p_tdo_quiet) else $error("tdo driven outside shift"); // RULE14

endmodule

// [sbs_tap_test.sv]
// Self-checking bench for the SRAM boundary scan test port.
// Assumes sbs_pkg, sbs_tap and the controller model sbs_jtag_host.
module sbs_tap_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [2:0] REV = 3'h3; // Arbitrary value
   localparam logic [16:0] DEV = 17'h0c1a5; // Arbitrary value
   localparam logic [10:0] VEN = 11'h1b7; // Arbitrary value
   localparam logic [31:0] ID_VAL = {REV, DEV, VEN, 1'b1};
   localparam logic [9:0] TMS_SEQ = 10'h1a9;
   logic clk, rst_b, psel, penable, pwrite, pready, pslverr, e, s, held;
   logic tck, tms, tms_drv, tdi, tdi_drv, tdo, tdo_oe_b, pad_drive, dq_hiz;
   logic [2:0] code;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, seed, r32;
   logic [106:0] pad_in, pad_out;
   logic [127:0] din, dout, cap, pad, g, x;
   logic [127:0] exp_q[$];
   logic [127:0] got_q[$];
   int err_total = 0;
   int cmp_count = 0;
   // Device and board-side controller
   sbs_tap #(.REV_ID(REV), .DEVICE_ID(DEV), .VENDOR_ID(VEN)) u_sbs_tap (
      .I_REF_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .I_TCK(tck), .I_TMS(tms),
      .I_TMS_DRIVEN(tms_drv), .I_TDI(tdi), .I_TDI_DRIVEN(tdi_drv), .O_TDO(tdo),
      .O_TDO_OE_B(tdo_oe_b), .I_PAD_IN(pad_in), .O_PAD_OUT(pad_out),
      .O_PAD_DRIVE(pad_drive), .O_DQ_HIZ(dq_hiz));
   sbs_jtag_host u_sbs_jtag_host (.o_tck(tck), .o_tms(tms), .o_tms_driven(tms_drv),
      .o_tdi(tdi), .o_tdi_driven(tdi_drv), .i_tdo(tdo), .i_tdo_oe_b(tdo_oe_b));
   // Reference clock, 20 ns
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Verdict and end of run
   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      #1ms;
      err_total++;
      stop_test();
   end
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic rand_fill(output logic [127:0] v);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         v[32*i +: 32] = seed;
      end
   endtask
   task automatic note(input logic [127:0] v);
      exp_q.push_back(v);
   endtask
   task automatic post(input logic [127:0] v);
      got_q.push_back(v);
   endtask
   // Result watcher pairs each result with the oldest expectation
   initial forever begin
      @(posedge clk);
      while (got_q.size() > 0) begin
         g = got_q.pop_front();
         x = exp_q.pop_front();
         cmp_count++;
         if (g !== x) begin
            err_total++;
            $display("wrong value at %0t: expected %h got %h", $time, x, g);
         end
      end
   end
   // One APB transfer, held until ready is sampled
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic er);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk);
      end
      // Timeout counts a mismatch; the verdict comes at the end of the run
      if (n == 50) err_total++;
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Main sequence
   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pad_in = '0;
      seed = 32'h812051e6;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      note(sbs_pkg::CTRL_RESET);
      apb(1'b0, sbs_pkg::OFF_CTRL, '0, r32, e);
      post(r32);
      note(1'b1);
      apb(1'b1, 8'h08, 32'hffffffff, r32, e);
      post(e);
      apb(1'b1, sbs_pkg::OFF_CTRL, 32'hfffffffe, r32, e);
      note(32'h0);
      apb(1'b0, sbs_pkg::OFF_CTRL, '0, r32, e);
      post(r32);
      apb(1'b1, sbs_pkg::OFF_CTRL, 32'h1, r32, e);
      $display("test registers done");
      u_sbs_jtag_host.tlr();
      rand_fill(din);
      note({din[31:0], ID_VAL});
      u_sbs_jtag_host.scan(1'b0, 64, din, dout);
      post(dout[63:0]);
      $display("test identification done");
      note(sbs_pkg::IR_CAPTURE);
      u_sbs_jtag_host.load_ir(sbs_pkg::INS_BYPASS, cap);
      post(cap[2:0]);
      note({din[7:0], 1'b0});
      u_sbs_jtag_host.scan(1'b0, 9, din, dout);
      post(dout[8:0]);
      note(1'b1);
      for (int i = 0; i < 10; i++) begin
         u_sbs_jtag_host.step(TMS_SEQ[i], 1'b1, s);
         if (i == 7) held = s;
      end
      post(held);
      $display("test bypass done");
      rand_fill(pad);
      @(posedge clk) pad_in <= pad[106:0];
      u_sbs_jtag_host.load_ir(sbs_pkg::INS_PRELOAD, cap);
      rand_fill(din);
      note({din[7:0], pad[106:0]});
      u_sbs_jtag_host.scan(1'b0, 115, din, dout);
      post(dout[114:0]);
      note(din[114:8]);
      post(pad_out);
      note(2'b00);
      post({pad_drive, dq_hiz});
      $display("test preload done");
      for (int k = 0; k < 2; k++) begin
         code = (k == 1) ? sbs_pkg::INS_EXTEST : sbs_pkg::INS_SAMPLEZ;
         rand_fill(pad);
         @(posedge clk) pad_in <= pad[106:0];
         u_sbs_jtag_host.load_ir(code, cap);
         note({k == 1, k == 0});
         post({pad_drive, dq_hiz});
         // Status shows pad drive under external test, float under sample-z
         note(32'h1 << ((k == 1) ? sbs_pkg::ST_DRIVE : sbs_pkg::ST_HIZ));
         apb(1'b0, sbs_pkg::OFF_STATUS, '0, r32, e);
         post(r32);
         note(pad[106:0]);
         u_sbs_jtag_host.scan(1'b0, 107, din, dout);
         post(dout[106:0]);
      end
      $display("test capture done");
      u_sbs_jtag_host.float_reset();
      note(1'b0);
      post(pad_drive);
      note(ID_VAL);
      u_sbs_jtag_host.scan(1'b0, 32, din, dout);
      post(dout[31:0]);
      note(2'b10);
      post({tdo_oe_b, u_sbs_jtag_host.oe_err != 0});
      $display("test undriven pins done");
      repeat (10) @(posedge clk);
      stop_test();
   end
endmodule
